// File: mrio_regs.svh
/*
 * constants of the motor remote i/o and response block: function codes,
 * default bit assignments, field positions, reset values.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef MRIO_REGS_SVH
`define MRIO_REGS_SVH

// word widths
`define MRIO_WORD_W 16
`define MRIO_FSEL_W 5
`define MRIO_CODE_W 12
`define MRIO_DATA_W 32

// input function codes
`define MRIO_IN_UNUSED 5'h00
`define MRIO_IN_OPSEL0 5'h01
`define MRIO_IN_OPSEL1 5'h02
`define MRIO_IN_OPSEL2 5'h03
`define MRIO_IN_OPSEL3 5'h04
`define MRIO_IN_FWD 5'h05
`define MRIO_IN_REV 5'h06
`define MRIO_IN_STOPMODE 5'h07
`define MRIO_IN_BRAKE 5'h08
`define MRIO_IN_PANEL 5'h09
`define MRIO_IN_TLIM 5'h0A
`define MRIO_IN_GEN0 5'h10

// output function codes
`define MRIO_OUT_UNUSED 5'h00
`define MRIO_OUT_ECHO0 5'h01
`define MRIO_OUT_ALARM 5'h0B
`define MRIO_OUT_WARN 5'h0C
`define MRIO_OUT_MOVE 5'h0D
`define MRIO_OUT_TLC 5'h0E
`define MRIO_OUT_VA 5'h0F
`define MRIO_OUT_BUSY 5'h10
`define MRIO_OUT_OVLD 5'h11
`define MRIO_OUT_MPS 5'h12
`define MRIO_OUT_DIR 5'h13
`define MRIO_OUT_GEN0 5'h14

// default assignment tables, bit 15 in the top slot
`define MRIO_IN_MAP_DEFAULT {{9{5'h00}}, 5'h08, 5'h07, 5'h06, 5'h05, 5'h03, 5'h02, 5'h01}
`define MRIO_OUT_MAP_DEFAULT {5'h0E, 5'h0F, 5'h0D, 5'h11, 5'h00, 5'h00, 5'h00, 5'h10, \
    5'h0B, 5'h0C, 5'h07, 5'h06, 5'h05, 5'h03, 5'h02, 5'h01}

// reset values of the response fields and output word, and the echo function count
`define MRIO_CODE_RST 12'h000
`define MRIO_DATA_RST 32'h0000_0000
`define MRIO_WORD_RST 16'h0000
`define MRIO_FN_ECHO_W 10

`endif

// File: mrio_pkg.sv
/*
 * types shared by the motor remote i/o block.
 * assumes the constants header is on the include path.
 */
`include "mrio_regs.svh"
package mrio_pkg;
    // response handshake states, gray coded along idle-busy-done
    typedef enum logic [1:0] {
        MRIO_IDLE = 2'h0,
        MRIO_BUSY = 2'h1,
        MRIO_DONE = 2'h3
    } mrio_state_e;

    // one function selector per remote bit
    typedef logic [`MRIO_FSEL_W-1:0] mrio_fsel_t;
endpackage

// File: mrio_in_decode.sv
/*
 * decodes the remote input word into motion functions by per-bit selector.
 * assumes selectors and word are on clock_i; purely combinational.
 */
`timescale 1ns/100ps
`include "mrio_regs.svh"
module mrio_in_decode (
    input wire logic [`MRIO_WORD_W-1:0] word_i,
    input wire logic [`MRIO_WORD_W*`MRIO_FSEL_W-1:0] map_i,
    input wire logic panel_direct_i,
    input wire logic tlim_direct_i,
    output logic [3:0] op_data_select_o,
    output logic run_forward_o,
    output logic run_reverse_o,
    output logic stop_mode_o,
    output logic brake_release_o,
    output logic panel_unlock_o,
    output logic torque_limit_enable_o,
    output logic [`MRIO_WORD_W-1:0] general_flags_o
);
    // per-bit hit vectors per function
    logic [`MRIO_WORD_W-1:0] hit_op0, hit_op1, hit_op2, hit_op3;
    logic [`MRIO_WORD_W-1:0] hit_fwd, hit_rev, hit_stop, hit_brk;
    logic [`MRIO_WORD_W-1:0] asg_pan, off_pan, asg_tl, off_tl;
    logic [`MRIO_WORD_W*`MRIO_WORD_W-1:0] hit_gen;

    genvar b, g;
    generate
        for (b = 0; b < `MRIO_WORD_W; b = b + 1) begin : g_bit
            wire [`MRIO_FSEL_W-1:0] sel = map_i[b*`MRIO_FSEL_W +: `MRIO_FSEL_W];
            assign hit_op0[b] = word_i[b] && (sel == `MRIO_IN_OPSEL0);
            assign hit_op1[b] = word_i[b] && (sel == `MRIO_IN_OPSEL1);
            assign hit_op2[b] = word_i[b] && (sel == `MRIO_IN_OPSEL2);
            assign hit_op3[b] = word_i[b] && (sel == `MRIO_IN_OPSEL3);
            assign hit_fwd[b] = word_i[b] && (sel == `MRIO_IN_FWD);
            assign hit_rev[b] = word_i[b] && (sel == `MRIO_IN_REV);
            assign hit_stop[b] = word_i[b] && (sel == `MRIO_IN_STOPMODE);
            assign hit_brk[b] = word_i[b] && (sel == `MRIO_IN_BRAKE);
            // normally-closed inputs track assignment and off bits separately
            assign asg_pan[b] = (sel == `MRIO_IN_PANEL);
            assign off_pan[b] = asg_pan[b] && !word_i[b];
            assign asg_tl[b] = (sel == `MRIO_IN_TLIM);
            assign off_tl[b] = asg_tl[b] && !word_i[b];
            for (g = 0; g < `MRIO_WORD_W; g = g + 1) begin : g_gen
                assign hit_gen[g*`MRIO_WORD_W + b] = word_i[b] &&
                    (sel == `MRIO_FSEL_W'(`MRIO_IN_GEN0 + g));
            end
        end
        for (g = 0; g < `MRIO_WORD_W; g = g + 1) begin : g_flag
            assign general_flags_o[g] = |hit_gen[g*`MRIO_WORD_W +: `MRIO_WORD_W];
        end
    endgenerate

    // duplicated assignments are ored together
    assign op_data_select_o = {|hit_op3, |hit_op2, |hit_op1, |hit_op0};
    assign run_forward_o = |hit_fwd;
    assign run_reverse_o = |hit_rev;
    assign stop_mode_o = |hit_stop;
    assign brake_release_o = |hit_brk;
    // unassigned reads on; several terminals are anded with the direct pin
    assign panel_unlock_o = !(|off_pan) && panel_direct_i;
    assign torque_limit_enable_o = !(|off_tl) && tlim_direct_i;
endmodule

// File: mrio_core.sv
/*
 * motor remote i/o and response core: decodes the remote input word,
 * builds the remote output word and answers the command handshake.
 * assumes all inputs are on clock_i except the status pins, which are
 * synchronised here; the command executor is outside and reports done.
 */
// Operation
// - response echoes the received command code
// - completion trigger 0 idle, 1 when done
// - status bit 0 normal, 1 error
// - response data little-endian byte order
// - sixteen input bits assignable, documented defaults
// - forward/reverse 0 stop, 1 rotate
// - stop-mode picks instant or deceleration stop
// - brake input holds or releases brake
// - four select bits pick operation data 0-15
// - torque-limit input 0 disables, 1 enables
// - duplicated input function ors its bits
// - panel/torque-limit unassigned on, several terminals anded
// - sixteen general flags in, flags 0-11 echoed out
// - sixteen output bits assignable, documented defaults
// - echo outputs mirror their input function
// - alarm output 1 when alarm present
// - warning output 1 when warning present
// - motion output 1 while motor operates
// - torque-at-limit and speed-attained status outputs
// - busy output during internal processing
// - overload output 1 on overload warning/alarm
// - main-power and direction status outputs
`timescale 1ns/100ps
`include "mrio_regs.svh"
module mrio_core (
    input wire logic clock_i,
    input wire logic rst_i,
    // remote input word and assignment tables
    input wire logic [`MRIO_WORD_W-1:0] remote_input_word_i,
    input wire logic [`MRIO_WORD_W*`MRIO_FSEL_W-1:0] in_map_i,
    input wire logic [`MRIO_WORD_W*`MRIO_FSEL_W-1:0] out_map_i,
    input wire logic map_load_i,
    input wire logic panel_direct_i,
    input wire logic tlim_direct_i,
    // drive status pins, asynchronous
    input wire logic alarm_i,
    input wire logic warning_i,
    input wire logic moving_i,
    input wire logic torque_at_limit_i,
    input wire logic speed_attained_i,
    input wire logic overload_i,
    input wire logic main_power_on_i,
    // command side
    input wire logic execute_trigger_i,
    input wire logic [`MRIO_CODE_W-1:0] command_code_i,
    input wire logic [`MRIO_DATA_W-1:0] write_data_i,
    // executor side
    output logic exec_start_o,
    output logic [`MRIO_CODE_W-1:0] exec_code_o,
    output logic [`MRIO_DATA_W-1:0] exec_data_o,
    input wire logic exec_done_i,
    input wire logic exec_error_i,
    input wire logic [`MRIO_DATA_W-1:0] exec_read_data_i,
    // decoded functions
    output logic [3:0] op_data_select_o,
    output logic run_forward_o,
    output logic run_reverse_o,
    output logic stop_mode_o,
    output logic brake_release_o,
    output logic panel_unlock_o,
    output logic torque_limit_enable_o,
    output logic [`MRIO_WORD_W-1:0] general_flags_o,
    // response and output word
    output logic [`MRIO_WORD_W-1:0] remote_output_word_o,
    output logic completion_trigger_o,
    output logic status_error_o,
    output logic [`MRIO_CODE_W-1:0] response_code_o,
    output logic [`MRIO_DATA_W-1:0] response_data_o
);
    // all state of the block
    typedef struct packed {
        logic [`MRIO_WORD_W*`MRIO_FSEL_W-1:0] in_map;
        logic [`MRIO_WORD_W*`MRIO_FSEL_W-1:0] out_map;
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic execute_trigger_prev;
        mrio_pkg::mrio_state_e state;
        logic busy;
        logic status;
        logic start;
        logic [`MRIO_CODE_W-1:0] code;
        logic [`MRIO_DATA_W-1:0] wdata;
        logic [`MRIO_DATA_W-1:0] rdata;
        logic [`MRIO_WORD_W-1:0] out_word;
        logic last_dir;
    } mrio_core_s;

    mrio_core_s state_reg;
    mrio_core_s state_next;

    // decoded input functions
    logic [3:0] opsel;
    logic run_forward, run_reverse, stopm, brk, pan, tlim;
    logic [`MRIO_WORD_W-1:0] gen;
    // synchronised status: alarm, warn, move, tlc, va, ovld, mps
    logic s_alarm, s_warn, s_move, s_tlc, s_va, s_ovld, s_mps;
    // candidate value of every output function, indexed by code
    logic [31:0] fn_val;
    logic [`MRIO_WORD_W-1:0] out_word_c;

    // selectors load from the table ports so the map behaves as parameters
    mrio_in_decode i_mrio_in_decode (
        .word_i(remote_input_word_i),
        .map_i(state_reg.in_map),
        .panel_direct_i(panel_direct_i),
        .tlim_direct_i(tlim_direct_i),
        .op_data_select_o(opsel),
        .run_forward_o(run_forward),
        .run_reverse_o(run_reverse),
        .stop_mode_o(stopm),
        .brake_release_o(brk),
        .panel_unlock_o(pan),
        .torque_limit_enable_o(tlim),
        .general_flags_o(gen)
    );

    assign {s_alarm, s_warn, s_move, s_tlc, s_va, s_ovld, s_mps} = state_reg.sync2;

    // function values for the output selector table
    always_comb begin
        fn_val = 32'h0000_0000;
        fn_val[`MRIO_OUT_ECHO0 +: `MRIO_FN_ECHO_W] = {tlim, pan, brk, stopm, run_reverse, run_forward, opsel};
        fn_val[`MRIO_OUT_ALARM] = s_alarm;
        fn_val[`MRIO_OUT_WARN] = s_warn;
        fn_val[`MRIO_OUT_MOVE] = s_move;
        fn_val[`MRIO_OUT_TLC] = s_tlc;
        fn_val[`MRIO_OUT_VA] = s_va;
        fn_val[`MRIO_OUT_BUSY] = state_reg.busy;
        fn_val[`MRIO_OUT_OVLD] = s_ovld;
        fn_val[`MRIO_OUT_MPS] = s_mps;
        // direction holds the last commanded sense once the motor stops
        fn_val[`MRIO_OUT_DIR] = state_reg.last_dir;
        fn_val[`MRIO_OUT_GEN0 +: 12] = gen[11:0];
    end

    // each output bit picks one function; the table spans all 32 codes and code 0 reads zero
    genvar ob;
    generate
        for (ob = 0; ob < `MRIO_WORD_W; ob = ob + 1) begin : g_out
            assign out_word_c[ob] = fn_val[state_reg.out_map[ob*`MRIO_FSEL_W +: `MRIO_FSEL_W]];
        end
    endgenerate

    // next-state logic
    always_comb begin
        state_next = state_reg;
        state_next.start = 1'b0;
        // status pins pass two flops before use
        state_next.sync1 = {alarm_i, warning_i, moving_i, torque_at_limit_i,
            speed_attained_i, overload_i, main_power_on_i};
        state_next.sync2 = state_reg.sync1;
        state_next.execute_trigger_prev = execute_trigger_i;
        state_next.out_word = out_word_c;
        if (map_load_i) begin
            // assignment tables change only on request
            state_next.in_map = in_map_i;
            state_next.out_map = out_map_i;
        end
        if (run_forward && !run_reverse) begin
            state_next.last_dir = 1'b1;
        end else if (run_reverse && !run_forward) begin
            state_next.last_dir = 1'b0;
        end
        unique case (state_reg.state)
            mrio_pkg::MRIO_IDLE: begin
                // a rising execute trigger captures code and data together
                if (execute_trigger_i && !state_reg.execute_trigger_prev) begin
                    state_next.state = mrio_pkg::MRIO_BUSY;
                    state_next.code = command_code_i;
                    state_next.wdata = write_data_i;
                    state_next.start = 1'b1;
                    state_next.busy = 1'b1;
                end
            end
            mrio_pkg::MRIO_BUSY: begin
                // completion stays low until the executor finishes
                if (exec_done_i) begin
                    state_next.state = mrio_pkg::MRIO_DONE;
                    state_next.status = exec_error_i;
                    state_next.rdata = exec_read_data_i;
                    state_next.busy = 1'b0;
                end
            end
            mrio_pkg::MRIO_DONE: begin
                // trigger low ends the handshake and clears completion
                if (!execute_trigger_i) begin
                    state_next.state = mrio_pkg::MRIO_IDLE;
                end
            end
            default: begin
                state_next.state = mrio_pkg::MRIO_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_reg.in_map <= `MRIO_IN_MAP_DEFAULT;
            state_reg.out_map <= `MRIO_OUT_MAP_DEFAULT;
            state_reg.sync1 <= 7'h00;
            state_reg.sync2 <= 7'h00;
            state_reg.execute_trigger_prev <= 1'b1;
            state_reg.state <= mrio_pkg::MRIO_IDLE;
            state_reg.busy <= 1'b0;
            state_reg.status <= 1'b0;
            state_reg.start <= 1'b0;
            state_reg.code <= `MRIO_CODE_RST;
            state_reg.wdata <= `MRIO_DATA_RST;
            state_reg.rdata <= `MRIO_DATA_RST;
            state_reg.out_word <= `MRIO_WORD_RST;
            state_reg.last_dir <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign exec_start_o = state_reg.start;
    assign exec_code_o = state_reg.code;
    assign exec_data_o = state_reg.wdata;
    assign op_data_select_o = opsel;
    assign run_forward_o = run_forward;
    assign run_reverse_o = run_reverse;
    assign stop_mode_o = stopm;
    assign brake_release_o = brk;
    assign panel_unlock_o = pan;
    assign torque_limit_enable_o = tlim;
    assign general_flags_o = gen;
    assign remote_output_word_o = state_reg.out_word;
    assign completion_trigger_o = (state_reg.state == mrio_pkg::MRIO_DONE);
    assign status_error_o = state_reg.status;
    assign response_code_o = state_reg.code;
    // data field byte 0 carries the least significant byte
    assign response_data_o = state_reg.rdata;
endmodule

// File: mrio_core_sva.sv
/* assertions on the core's ports: command capture, response handshake, input gating, echo.
   assumes a bind onto mrio_core and the constants header on the include path. */
`timescale 1ns/100ps
`include "mrio_regs.svh"
module mrio_core_sva (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic map_load_i,
    input wire logic [79:0] out_map_i,
    input wire logic panel_direct_i,
    input wire logic tlim_direct_i,
    input wire logic execute_trigger_i,
    input wire logic [11:0] command_code_i,
    input wire logic [31:0] write_data_i,
    input wire logic exec_start_o,
    input wire logic [11:0] exec_code_o,
    input wire logic [31:0] exec_data_o,
    input wire logic exec_done_i,
    input wire logic exec_error_i,
    input wire logic [31:0] exec_read_data_i,
    input wire logic [3:0] op_data_select_o,
    input wire logic panel_unlock_o,
    input wire logic torque_limit_enable_o,
    input wire logic [15:0] remote_output_word_o,
    input wire logic completion_trigger_o,
    input wire logic status_error_o,
    input wire logic [11:0] response_code_o,
    input wire logic [31:0] response_data_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // own copy of slot 0 of the output table, so the echo check follows a reload
    logic [4:0] slot0_reg;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            slot0_reg <= `MRIO_OUT_ECHO0;
        end else if (map_load_i) begin
            slot0_reg <= out_map_i[4:0];
        end
    end
    // code seen on the command side when the start went out, kept for the answer
    logic [11:0] taken_code_reg;
    always_ff @(posedge clock_i) begin
        if (exec_start_o) begin
            taken_code_reg <= $past(command_code_i);
        end
    end
    property p_take;
        exec_start_o |-> $past(execute_trigger_i) && !$past(execute_trigger_i, 2)
            && exec_code_o == $past(command_code_i) && exec_data_o == $past(write_data_i);
    endproperty
    a_take: assert property (p_take) else $error("start without a clean trigger rise");
    property p_code;
        $rose(completion_trigger_o) |-> response_code_o == taken_code_reg;
    endproperty
    a_code: assert property (p_code) else $error("response code differs");
    property p_done;
        $rose(completion_trigger_o) |-> $past(exec_done_i);
    endproperty
    a_done: assert property (p_done) else $error("completion without done");
    property p_stat;
        $rose(completion_trigger_o) |-> status_error_o == $past(exec_error_i);
    endproperty
    a_stat: assert property (p_stat) else $error("status bit wrong");
    property p_data;
        $rose(completion_trigger_o) |-> response_data_o == $past(exec_read_data_i);
    endproperty
    a_data: assert property (p_data) else $error("response data wrong");
    property p_hold;
        completion_trigger_o && execute_trigger_i |=> completion_trigger_o && $stable(response_data_o);
    endproperty
    a_hold: assert property (p_hold) else $error("response did not stand");
    property p_clear;
        completion_trigger_o && !execute_trigger_i |=> !completion_trigger_o;
    endproperty
    a_clear: assert property (p_clear) else $error("completion not cleared");
    property p_panel;
        !panel_direct_i |-> !panel_unlock_o;
    endproperty
    a_panel: assert property (p_panel) else $error("panel unlock ignores direct terminal");
    property p_tlim;
        !tlim_direct_i |-> !torque_limit_enable_o;
    endproperty
    a_tlim: assert property (p_tlim) else $error("torque limit ignores direct terminal");
    property p_echo;
        slot0_reg == `MRIO_OUT_ECHO0 && $stable(slot0_reg) && !$past(rst_i)
            |-> remote_output_word_o[0] == $past(op_data_select_o[0]);
    endproperty
    a_echo: assert property (p_echo) else $error("select echo wrong");
    c_err: cover property ($rose(completion_trigger_o) && status_error_o);
    c_load: cover property (map_load_i);
    c_start: cover property (exec_start_o);
endmodule
bind mrio_core mrio_core_sva i_mrio_core_sva (.*);

// File: mrio_ctrl_model.sv
/* network converter model: runs the execute trigger handshake with the core.
   assumes the testbench calls issue from one process at a time. */
`timescale 1ns/100ps
module mrio_ctrl_model (
    input wire logic clock_i,
    input wire logic completion_trigger_i,
    output logic execute_trigger_o,
    output logic [11:0] command_code_o,
    output logic [31:0] write_data_o
);
    initial begin
        execute_trigger_o = 1'b0;
        command_code_o = 12'h000;
        write_data_o = 32'h0000_0000;
    end
    // one whole command; ok stays low if the core never answers or never clears
    task automatic issue(input logic [11:0] code, input logic [31:0] data, output logic ok);
        int n;
        int m;
        @(posedge clock_i);
        #2;
        command_code_o = code;
        write_data_o = data;
        execute_trigger_o = 1'b1;
        for (n = 0; n < 40 && completion_trigger_i !== 1'b1; n++) begin
            @(posedge clock_i);
            #1;
        end
        #1;
        execute_trigger_o = 1'b0;
        command_code_o = ~code; // stale lines are inverted so nothing leans on them
        write_data_o = ~data;
        for (m = 0; m < 40 && completion_trigger_i !== 1'b0; m++) begin
            @(posedge clock_i);
            #1;
        end
        ok = (n < 40) && (m < 40);
    endtask
endmodule

// File: testbench.sv
/* self-checking bench for mrio_core: default and reloaded tables, then commands.
   assumes the checker is bound in and the controller model drives the command side. */
`timescale 1ns/100ps
`include "mrio_regs.svh"
module testbench;
    logic clock_i, rst_i, map_load_i, panel_direct_i, tlim_direct_i, execute_trigger_i, exec_start_o;
    logic alarm_i, warning_i, moving_i, torque_at_limit_i, speed_attained_i, overload_i, main_power_on_i;
    logic exec_done_i, exec_error_i, run_forward_o, run_reverse_o, stop_mode_o, brake_release_o;
    logic panel_unlock_o, torque_limit_enable_o, completion_trigger_o, status_error_o, ok, dir_exp;
    logic [15:0] remote_input_word_i, general_flags_o, remote_output_word_o, w;
    logic [79:0] in_map_i, out_map_i;
    logic [11:0] command_code_i, exec_code_o, response_code_o, cur_code;
    logic [31:0] write_data_i, exec_data_o, exec_read_data_i, response_data_o, d, seed;
    logic [3:0] op_data_select_o;
    logic [6:0] pins; // alarm, warning, moving, tlc, va, overload, main power from bit 0 up
    logic [44:0] exp_q[$]; // code, error, data of each answer the executor gave
    logic [44:0] got_e;
    logic prev_done;
    int failures = 0;
    int checks = 0;
    int resp_n = 0;
    int i;
    assign {main_power_on_i, overload_i, speed_attained_i, torque_at_limit_i, moving_i, warning_i, alarm_i} = pins;
    mrio_core i_mrio_core (.*);
    mrio_ctrl_model i_mrio_ctrl_model (.clock_i(clock_i), .completion_trigger_i(completion_trigger_o),
        .execute_trigger_o(execute_trigger_i), .command_code_o(command_code_i), .write_data_o(write_data_i));
    task compare_val(input logic [79:0] seen, input logic [79:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask
    // executor: answers each start after 0 to 2 cycles and notes the expected response
    task automatic serve();
        logic e;
        logic [31:0] r;
        repeat ($urandom % 3) @(posedge clock_i);
        #2;
        e = $urandom;
        r = $urandom;
        exec_done_i = 1'b1;
        exec_error_i = e;
        exec_read_data_i = r;
        exp_q.push_back({cur_code, e, r});
        @(posedge clock_i);
        #2;
        exec_done_i = 1'b0;
        exec_error_i = ~e;
        exec_read_data_i = ~r;
    endtask
    always @(posedge clock_i) if (exec_start_o === 1'b1) serve();
    // response watcher: every completion rise takes the oldest note
    always @(posedge clock_i) begin
        #1;
        if (completion_trigger_o === 1'b1 && prev_done === 1'b0) begin
            resp_n++;
            if (exp_q.size() == 0) compare_val(80'h1, 80'h0);
            else begin
                got_e = exp_q.pop_front();
                compare_val(response_code_o, got_e[44:33]);
                compare_val(status_error_o, got_e[32]);
                compare_val(response_data_o, got_e[31:0]);
            end
        end
        prev_done = completion_trigger_o;
    end
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        seed = $urandom(83);
        {rst_i, panel_direct_i, tlim_direct_i, dir_exp} = 4'hF;
        {map_load_i, exec_done_i, exec_error_i} = 3'h0;
        {pins, remote_input_word_i, exec_read_data_i} = 55'h0;
        in_map_i = `MRIO_IN_MAP_DEFAULT;
        out_map_i = `MRIO_OUT_MAP_DEFAULT;
        tick(6);
        rst_i = 1'b0;
        for (i = 0; i < 8; i++) begin
            remote_input_word_i = $urandom;
            pins = $urandom;
            w = remote_input_word_i;
            if (w[3] ^ w[4]) dir_exp = w[3];
            tick(4);
            compare_val({op_data_select_o, run_forward_o, run_reverse_o, stop_mode_o, brake_release_o, panel_unlock_o,
                torque_limit_enable_o}, {1'b0, w[2:0], w[3], w[4], w[5], w[6], 2'h3});
            compare_val(general_flags_o, 16'h0000);
            compare_val(remote_output_word_o, {pins[3], pins[4], pins[2], pins[5], 4'h0, pins[0], pins[1],
                w[5:0]});
        end
        $display("test default tables done");
        in_map_i = {50'h0, 5'h15, 5'h04, 5'h0A, 5'h09, 5'h05, 5'h05};
        out_map_i = {45'h0, 5'h19, 5'h04, 5'h05, 5'h13, 5'h12, 5'h0A, 5'h09};
        remote_input_word_i = 16'h0001;
        map_load_i = 1'b1;
        tick(1);
        map_load_i = 1'b0;
        dir_exp = 1'b1;
        for (i = 0; i < 8; i++) begin
            remote_input_word_i = $urandom;
            {pins, panel_direct_i, tlim_direct_i} = $urandom;
            w = remote_input_word_i;
            tick(4);
            compare_val({op_data_select_o, run_forward_o, panel_unlock_o, torque_limit_enable_o}, {w[4], 3'h0,
                w[0] | w[1], w[2] & panel_direct_i, w[3] & tlim_direct_i});
            compare_val(general_flags_o, {10'h000, w[5], 5'h00});
            compare_val(remote_output_word_o, {9'h000, w[5], w[4], w[0] | w[1], dir_exp, pins[6],
                w[3] & tlim_direct_i, w[2] & panel_direct_i});
        end
        $display("test reloaded tables done");
        for (i = 0; i < 6; i++) begin
            cur_code = $urandom;
            d = $urandom;
            i_mrio_ctrl_model.issue(cur_code, d, ok);
            if (ok !== 1'b1) begin
                failures++;
                report_and_stop();
            end
        end
        tick(4);
        compare_val(resp_n, 80'h6);
        compare_val(exp_q.size(), 80'h0);
        $display("test command handshake done");
        report_and_stop();
    end
endmodule
